/* rtl/mcas_pkg.sv */
package mcas_pkg;
  // ==========================================================
  // Sizes.
  localparam int NCHAN = 20;
  localparam int NCORE = 3;
  localparam int NDED = 2;
  localparam int NSRC = 5;
  localparam int NCMP = 4;
  localparam int NFLT = 4;
  localparam int SMP_W = 12;
  localparam int DATA_W = 16;
  localparam int ST_W = 9;
  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SWTRIG = 8'h04;
  localparam logic [7:0] OFS_FORMAT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_PEND = 8'h14;
  localparam logic [7:0] OFS_CORECFG = 8'h18;
  localparam logic [7:0] OFS_TRIGSEL = 8'h24;
  localparam logic [7:0] OFS_CMP = 8'h30;
  localparam logic [7:0] OFS_FLT = 8'h40;
  localparam logic [7:0] OFS_RESULT = 8'h80;
  // ==========================================================
  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_SAMC_LSB = 8;
  localparam int CFG_RES_LSB = 20;
  localparam int PEND_BUSY_LSB = 24;
  localparam int TSEL_STRIDE = 4;
  localparam int TSEL_PER_REG = 8;
  localparam int UNIT_MODE_LSB = 8;
  localparam int UNIT_EN_BIT = 15;
  localparam int UNIT_HI_LSB = 16;
  localparam int ST_CMP_LSB = 0;
  localparam int ST_FLT_LSB = 4;
  localparam int ST_CONV_BIT = 8;
  // ==========================================================
  // Reset values.
  localparam logic [1:0] RES_RST = 2'h3;
  localparam logic [6:0] DIV_RST = 7'h00;
  localparam logic [9:0] SAMC_RST = 10'h000;
  // ==========================================================
  // Types.
  typedef struct packed {
    logic [1:0] res;
    logic [9:0] samc;
    logic [6:0] div;
  } mcas_corecfg_type;
  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [15:0] data;
  } mcas_result_type;
  typedef enum logic [1:0] {
    CMP_GE = 2'b00,
    CMP_LT = 2'b01,
    CMP_EQ = 2'b10,
    CMP_NE = 2'b11
  } mcas_cmpmode_type;
  typedef struct packed {
    logic on;
    mcas_cmpmode_type mode;
    logic [4:0] chan;
    logic [15:0] thr;
  } mcas_cmpcfg_type;
  typedef struct packed {
    logic on;
    logic [1:0] ratio;
    logic [4:0] chan;
  } mcas_fltcfg_type;
  typedef enum logic [1:0] {
    CORE_IDLE = 2'b00,
    CORE_SAMPLE = 2'b01,
    CORE_CONVERT = 2'b10
  } mcas_corest_type;
  // ==========================================================
  // Resolution code to bit count: 6, 8, 10 or 12.
  function automatic logic [3:0] resBits(input logic [1:0] code);
    return 4'h6 + {1'b0, code, 1'b0};
  endfunction : resBits
  // Divider code to source clocks per core clock period.
  function automatic logic [7:0] divPeriod(input logic [6:0] code);
    return (code < 7'h02) ? 8'h02 : {code, 1'b0};
  endfunction : divPeriod
endpackage : mcas_pkg

/* rtl/mcas_result_ram.sv */
`timescale 1ns/1ps
module mcas_result_ram #(
  parameter int DEPTH = 20,
  parameter int WIDTH = 16,
  parameter int NWR = 3,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Write ports, one per converter core.
  input wire logic [NWR-1:0] wrEn,
  input wire logic [NWR-1:0][AW-1:0] wrAddr,
  input wire logic [NWR-1:0][WIDTH-1:0] wrData,
  // Registered read port.
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [DEPTH-1:0][WIDTH-1:0] mem_d;
  logic [WIDTH-1:0] rdData_q;
  logic [WIDTH-1:0] rdData_d;

  // Each core owns a disjoint set of inputs, so ports never collide.
  always_comb begin
    mem_d = mem_q;
    for (int p = 0; p < NWR; p++) begin
      if (wrEn[p] && (int'(wrAddr[p]) < DEPTH)) begin
        mem_d[wrAddr[p]] = wrData[p];
      end
    end
    rdData_d = (int'(rdAddr) < DEPTH) ? mem_q[rdAddr] : '0;
  end

  // Storage and read register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q <= '0;
      rdData_q <= '0;
    end else begin
      mem_q <= mem_d;
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;
endmodule : mcas_result_ram

/* rtl/mcas_sar_core.sv */
`timescale 1ns/1ps
module mcas_sar_core (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Configuration and start request.
  input wire mcas_pkg::mcas_corecfg_type cfg,
  input wire logic start,
  input wire logic [4:0] startChan,
  input wire logic startSigned,
  // Sample word from the front end.
  input wire logic [11:0] sampleIn,
  // State and result.
  output logic busy,
  output logic sampling,
  output logic [4:0] sampleChan,
  output mcas_pkg::mcas_result_type result
);
  mcas_pkg::mcas_corest_type state_q, state_d;
  mcas_pkg::mcas_corecfg_type cfg_q, cfg_d;
  mcas_pkg::mcas_result_type res_q, res_d;
  logic [7:0] divCnt_q, divCnt_d;
  logic [10:0] perCnt_q, perCnt_d;
  logic [4:0] chan_q, chan_d;
  logic sgn_q, sgn_d;
  logic [11:0] smp_q, smp_d;
  logic tick;
  logic [3:0] bits;
  logic [15:0] raw;
  logic [15:0] half;

  // ==========================================================
  // Sample, then resolve one bit per core clock period.
  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    chan_d = chan_q;
    sgn_d = sgn_q;
    smp_d = smp_q;
    perCnt_d = perCnt_q;
    res_d = res_q;
    res_d.valid = 1'b0;
    // [R14] core clock divider
    tick = divCnt_q == mcas_pkg::divPeriod(cfg_q.div) - 8'h01;
    divCnt_d = tick ? 8'h00 : divCnt_q + 8'h01;
    // [R13] configurable resolution
    bits = mcas_pkg::resBits(cfg_q.res);
    raw = 16'(smp_q >> (4'hC - bits));
    half = 16'h0001 << (bits - 4'h1);
    unique case (state_q)
      mcas_pkg::CORE_IDLE: begin
        divCnt_d = 8'h00;
        // [R8] latch channel settings
        if (start) begin
          state_d = mcas_pkg::CORE_SAMPLE;
          cfg_d = cfg;
          chan_d = startChan;
          sgn_d = startSigned;
          perCnt_d = 11'h000;
        end
      end
      mcas_pkg::CORE_SAMPLE: begin
        // [R15] sample time in periods
        if (tick) begin
          if (perCnt_q == {1'b0, cfg_q.samc} + 11'h001) begin
            smp_d = sampleIn;
            perCnt_d = 11'h000;
            state_d = mcas_pkg::CORE_CONVERT;
          end else begin
            perCnt_d = perCnt_q + 11'h001;
          end
        end
      end
      mcas_pkg::CORE_CONVERT: begin
        if (tick) begin
          if (perCnt_q == {7'h00, bits} - 11'h001) begin
            res_d.valid = 1'b1;
            res_d.chan = chan_q;
            // [R9] signed or unsigned result
            res_d.data = sgn_q ? raw - half : raw;
            state_d = mcas_pkg::CORE_IDLE;
          end else begin
            perCnt_d = perCnt_q + 11'h001;
          end
        end
      end
      default: state_d = mcas_pkg::CORE_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= mcas_pkg::CORE_IDLE;
      cfg_q <= '{res: mcas_pkg::RES_RST, samc: mcas_pkg::SAMC_RST,
                 div: mcas_pkg::DIV_RST};
      res_q <= '0;
      divCnt_q <= 8'h00;
      perCnt_q <= 11'h000;
      chan_q <= 5'h00;
      sgn_q <= 1'b0;
      smp_q <= 12'h000;
    end else begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      res_q <= res_d;
      divCnt_q <= divCnt_d;
      perCnt_q <= perCnt_d;
      chan_q <= chan_d;
      sgn_q <= sgn_d;
      smp_q <= smp_d;
    end
  end

  assign busy = state_q != mcas_pkg::CORE_IDLE;
  assign sampling = state_q == mcas_pkg::CORE_SAMPLE;
  assign sampleChan = chan_q;
  assign result = res_q;
endmodule : mcas_sar_core

/* rtl/mcas_sequencer.sv */
`timescale 1ns/1ps
// How it works
// [R1] Two dedicated cores, one shared core.
// [R2] Three inputs may sample at once.
// [R3] Shared core serves lowest pending input first.
// [R4] Each input selects its own trigger.
// [R5] Twenty inputs, each with 16-bit result.
// [R6] Result lands in that input's register.
// [R7] Results also feed matching comparators, filters.
// [R8] Core uses channel format and number.
// [R9] Signed or unsigned format per input.
// [R10] Triggers from timers, logic, pin, software.
// [R11] Four comparators, own interrupt each.
// [R12] Four oversampling filters, own interrupt each.
// [R13] Resolution is software set, 12 max.
// [R14] Core clock divides source by code; the divider uses twice the code, at least 2.
// [R15] Sample time code plus two periods.
// [R16] Resolution code: 6, 8, 10, 12.
// [R17] Busy-core requests stay pending, rearbitrated.
module mcas_sequencer #(
  parameter int NCHAN = mcas_pkg::NCHAN
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM register slave.
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Trigger source events, asynchronous to clk.
  input wire logic [mcas_pkg::NSRC-1:0] trigIn,
  // Front end: sample word in, input select out, per core.
  input wire logic [2:0][11:0] coreSample,
  output logic [2:0][4:0] sampleChan,
  output logic [2:0] sampling,
  // Interrupts.
  output logic [3:0] cmpIrq,
  output logic [3:0] fltIrq,
  output logic irq
);
  localparam int NC = mcas_pkg::NCORE;
  localparam int ND = mcas_pkg::NDED;
  localparam int SW = mcas_pkg::ST_W;

  if (NCHAN <= ND || NCHAN > 24) begin : g_chk
    $error("NCHAN must lie between 3 and 24");
  end

  logic [1:0] rstSync_q;
  logic rst_n;
  logic [mcas_pkg::NSRC-1:0] trigMeta_q, trigSync_q, trigPrev_q;
  logic [mcas_pkg::NSRC-1:0] trigEdge;
  logic ack_q, ack_d, en_q, en_d, resSel_q, resSel_d, wrEn;
  logic [31:0] rdReg_q, rdReg_d, rd;
  logic [NCHAN-1:0] fmt_q, fmt_d, swTrig, chTrig;
  logic [NCHAN-1:0] pend_q, pend_d, take;
  logic [SW-1:0] mask_q, mask_d, st_q, st_d, stClr, stEv;
  logic [NCHAN-1:0][2:0] tsel_q, tsel_d;
  mcas_pkg::mcas_corecfg_type [NC-1:0] cfg_q, cfg_d;
  mcas_pkg::mcas_cmpcfg_type [3:0] cmp_q, cmp_d;
  mcas_pkg::mcas_fltcfg_type [3:0] flt_q, flt_d;
  logic [3:0][23:0] acc_q, acc_d;
  logic [3:0][7:0] cnt_q, cnt_d;
  logic [3:0][15:0] fOut_q, fOut_d;
  logic [3:0] cmpEv, fltEv;
  logic [NC-1:0] coreStart, coreBusy, resValid;
  logic [NC-1:0][4:0] coreChan, resChan;
  logic [NC-1:0][15:0] resData;
  mcas_pkg::mcas_result_type [NC-1:0] coreRes;
  logic [15:0] ramData;
  logic [4:0] shChan;
  logic [23:0] sum;
  logic [8:0] ratioN;
  logic hit;

  // ==========================================================
  // Reset release and trigger synchronisers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rst_n = rstSync_q[1];

  // Two stages, then a rising-edge detector on the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigMeta_q <= '0;
      trigSync_q <= '0;
      trigPrev_q <= '0;
    end else begin
      trigMeta_q <= trigIn;
      trigSync_q <= trigMeta_q;
      trigPrev_q <= trigSync_q;
    end
  end
  assign trigEdge = trigSync_q & ~trigPrev_q;

  // ==========================================================
  // Register slave: one wait cycle, then the access completes.
  always_comb begin
    ack_d = (read | write) & ~ack_q;
    wrEn = write & ack_q;
    en_d = en_q;
    fmt_d = fmt_q;
    mask_d = mask_q;
    cfg_d = cfg_q;
    tsel_d = tsel_q;
    cmp_d = cmp_q;
    flt_d = flt_q;
    swTrig = '0;
    stClr = '0;
    rd = 32'h0000_0000;
    if (wrEn) begin
      case (address)
        mcas_pkg::OFS_CTRL: en_d = writedata[mcas_pkg::CTRL_EN_BIT];
        // [R10] software trigger
        mcas_pkg::OFS_SWTRIG: swTrig = writedata[NCHAN-1:0];
        // [R9] per-input format
        mcas_pkg::OFS_FORMAT: fmt_d = writedata[NCHAN-1:0];
        mcas_pkg::OFS_STATUS: stClr = writedata[SW-1:0];
        mcas_pkg::OFS_MASK: mask_d = writedata[SW-1:0];
        default: ;
      endcase
      for (int i = 0; i < NC; i++) begin
        // [R16] resolution code field
        if (address == mcas_pkg::OFS_CORECFG + 8'(4 * i)) begin
          cfg_d[i].div = writedata[mcas_pkg::CFG_DIV_LSB +: 7];
          cfg_d[i].samc = writedata[mcas_pkg::CFG_SAMC_LSB +: 10];
          cfg_d[i].res = writedata[mcas_pkg::CFG_RES_LSB +: 2];
        end
      end
      for (int c = 0; c < NCHAN; c++) begin
        if (address == mcas_pkg::OFS_TRIGSEL +
            8'(4 * (c / mcas_pkg::TSEL_PER_REG))) begin
          tsel_d[c] = writedata[mcas_pkg::TSEL_STRIDE *
                                (c % mcas_pkg::TSEL_PER_REG) +: 3];
        end
      end
      for (int k = 0; k < 4; k++) begin
        if (address == mcas_pkg::OFS_CMP + 8'(4 * k)) begin
          cmp_d[k] = {writedata[mcas_pkg::UNIT_EN_BIT],
                      writedata[mcas_pkg::UNIT_MODE_LSB +: 2],
                      writedata[4:0], writedata[mcas_pkg::UNIT_HI_LSB +: 16]};
        end
        if (address == mcas_pkg::OFS_FLT + 8'(4 * k)) begin
          flt_d[k] = {writedata[mcas_pkg::UNIT_EN_BIT],
                      writedata[mcas_pkg::UNIT_MODE_LSB +: 2], writedata[4:0]};
        end
      end
    end
    case (address)
      mcas_pkg::OFS_CTRL: rd[mcas_pkg::CTRL_EN_BIT] = en_q;
      mcas_pkg::OFS_FORMAT: rd[NCHAN-1:0] = fmt_q;
      mcas_pkg::OFS_STATUS: rd[SW-1:0] = st_q;
      mcas_pkg::OFS_MASK: rd[SW-1:0] = mask_q;
      mcas_pkg::OFS_PEND: begin
        rd[NCHAN-1:0] = pend_q;
        rd[mcas_pkg::PEND_BUSY_LSB +: NC] = coreBusy;
      end
      default: ;
    endcase
    for (int i = 0; i < NC; i++) begin
      if (address == mcas_pkg::OFS_CORECFG + 8'(4 * i)) begin
        rd[mcas_pkg::CFG_DIV_LSB +: 7] = cfg_q[i].div;
        rd[mcas_pkg::CFG_SAMC_LSB +: 10] = cfg_q[i].samc;
        rd[mcas_pkg::CFG_RES_LSB +: 2] = cfg_q[i].res;
      end
    end
    for (int c = 0; c < NCHAN; c++) begin
      if (address == mcas_pkg::OFS_TRIGSEL +
          8'(4 * (c / mcas_pkg::TSEL_PER_REG))) begin
        rd[mcas_pkg::TSEL_STRIDE * (c % mcas_pkg::TSEL_PER_REG) +: 3] =
          tsel_q[c];
      end
    end
    for (int k = 0; k < 4; k++) begin
      if (address == mcas_pkg::OFS_CMP + 8'(4 * k)) begin
        rd = {cmp_q[k].thr, cmp_q[k].on, 5'h00, cmp_q[k].mode,
              3'h0, cmp_q[k].chan};
      end
      if (address == mcas_pkg::OFS_FLT + 8'(4 * k)) begin
        rd = {fOut_q[k], flt_q[k].on, 5'h00, flt_q[k].ratio,
              3'h0, flt_q[k].chan};
      end
    end
    resSel_d = resSel_q;
    rdReg_d = rdReg_q;
    if (ack_d && read) begin
      resSel_d = address[7] && (int'(address[6:2]) < NCHAN);
      rdReg_d = rd;
    end
  end

  // Register file and read data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      en_q <= 1'b0;
      fmt_q <= '0;
      mask_q <= '0;
      tsel_q <= '0;
      cmp_q <= '0;
      flt_q <= '0;
      resSel_q <= 1'b0;
      rdReg_q <= 32'h0000_0000;
      for (int i = 0; i < NC; i++) begin
        cfg_q[i] <= '{res: mcas_pkg::RES_RST, samc: mcas_pkg::SAMC_RST,
                      div: mcas_pkg::DIV_RST};
      end
    end else begin
      ack_q <= ack_d;
      en_q <= en_d;
      fmt_q <= fmt_d;
      mask_q <= mask_d;
      tsel_q <= tsel_d;
      cmp_q <= cmp_d;
      flt_q <= flt_d;
      cfg_q <= cfg_d;
      resSel_q <= resSel_d;
      rdReg_q <= rdReg_d;
    end
  end
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata = resSel_q ? {16'h0000, ramData} : rdReg_q;

  // ==========================================================
  // Trigger selection, pending requests and arbitration.
  always_comb begin
    for (int c = 0; c < NCHAN; c++) begin
      // [R4] per-input trigger source
      chTrig[c] = en_q & (swTrig[c] | ((tsel_q[c] != 3'h0) &&
                  (tsel_q[c] <= 3'(mcas_pkg::NSRC)) &&
                  trigEdge[tsel_q[c] - 3'h1]));
    end
    take = '0;
    coreStart = '0;
    // [R2] dedicated cores start independently
    for (int i = 0; i < ND; i++) begin
      coreChan[i] = 5'(i);
      if (en_q && pend_q[i] && !coreBusy[i]) begin
        coreStart[i] = 1'b1;
        take[i] = 1'b1;
      end
    end
    // [R3] lowest pending input wins
    shChan = 5'(ND);
    for (int c = NCHAN - 1; c >= ND; c--) begin
      if (pend_q[c]) begin
        shChan = 5'(c);
      end
    end
    coreChan[ND] = shChan;
    if (en_q && (|pend_q[NCHAN-1:ND]) && !coreBusy[ND]) begin
      coreStart[ND] = 1'b1;
      take[shChan] = 1'b1;
    end
    // [R17] busy requests stay pending
    pend_d = ((pend_q & ~take) | chTrig) & {NCHAN{en_q}};
  end

  // Pending request flags.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // [R1] two dedicated cores and one shared core
  for (genvar g = 0; g < NC; g++) begin : g_core
    mcas_sar_core u_core (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(cfg_q[g]),
      .start(coreStart[g]),
      .startChan(coreChan[g]),
      .startSigned(fmt_q[coreChan[g]]),
      .sampleIn(coreSample[g]),
      .busy(coreBusy[g]),
      .sampling(sampling[g]),
      .sampleChan(sampleChan[g]),
      .result(coreRes[g])
    );
    assign resValid[g] = coreRes[g].valid;
    assign resChan[g] = coreRes[g].chan;
    assign resData[g] = coreRes[g].data;
  end

  // [R5] one 16-bit result per input
  mcas_result_ram #(
    .DEPTH(NCHAN),
    .WIDTH(mcas_pkg::DATA_W),
    .NWR(NC),
    .AW(5)
  ) u_ram (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(resValid),
    // [R6] input's own word
    .wrAddr(resChan),
    .wrData(resData),
    .rdAddr(address[6:2]),
    .rdData(ramData)
  );

  // ==========================================================
  // [R7] comparators and filters watch results
  always_comb begin
    acc_d = acc_q;
    cnt_d = cnt_q;
    fOut_d = fOut_q;
    cmpEv = '0;
    fltEv = '0;
    sum = 24'h00_0000;
    ratioN = 9'h000;
    hit = 1'b0;
    for (int k = 0; k < 4; k++) begin
      for (int g = 0; g < NC; g++) begin
        // [R11] comparator on assigned input
        if (cmp_q[k].on && resValid[g] && resChan[g] == cmp_q[k].chan) begin
          unique case (cmp_q[k].mode)
            mcas_pkg::CMP_GE: hit = resData[g] >= cmp_q[k].thr;
            mcas_pkg::CMP_LT: hit = resData[g] < cmp_q[k].thr;
            mcas_pkg::CMP_EQ: hit = resData[g] == cmp_q[k].thr;
            mcas_pkg::CMP_NE: hit = resData[g] != cmp_q[k].thr;
          endcase
          cmpEv[k] = cmpEv[k] | hit;
        end
        // [R12] accumulate 4, 16, 64 or 256 samples
        if (flt_q[k].on && resValid[g] && resChan[g] == flt_q[k].chan) begin
          sum = acc_q[k] + {8'h00, resData[g]};
          ratioN = 9'h004 << {flt_q[k].ratio, 1'b0};
          if ({1'b0, cnt_q[k]} == ratioN - 9'h001) begin
            fOut_d[k] = 16'(sum >> ({1'b0, flt_q[k].ratio} + 3'h1));
            acc_d[k] = 24'h00_0000;
            cnt_d[k] = 8'h00;
            fltEv[k] = 1'b1;
          end else begin
            acc_d[k] = sum;
            cnt_d[k] = cnt_q[k] + 8'h01;
          end
        end
      end
      if (!flt_q[k].on) begin
        acc_d[k] = 24'h00_0000;
        cnt_d[k] = 8'h00;
      end
    end
    stEv = '0;
    stEv[mcas_pkg::ST_CMP_LSB +: 4] = cmpEv;
    stEv[mcas_pkg::ST_FLT_LSB +: 4] = fltEv;
    stEv[mcas_pkg::ST_CONV_BIT] = |resValid;
    // A new event wins over a same-cycle clear.
    st_d = (st_q & ~stClr) | stEv;
  end

  // Filter state and sticky status.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      cnt_q <= '0;
      fOut_q <= '0;
      st_q <= '0;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      fOut_q <= fOut_d;
      st_q <= st_d;
    end
  end
  assign cmpIrq = st_q[mcas_pkg::ST_CMP_LSB +: 4] &
                  mask_q[mcas_pkg::ST_CMP_LSB +: 4];
  assign fltIrq = st_q[mcas_pkg::ST_FLT_LSB +: 4] &
                  mask_q[mcas_pkg::ST_FLT_LSB +: 4];
  assign irq = |(st_q & mask_q);
endmodule : mcas_sequencer

/* verif/mcas_front_end.sv */
`timescale 1ns/1ps
// ==========
// Front end and trigger sources around the sequencer.
module mcas_front_end (
  // Clock.
  input wire logic clk,
  // Core input select.
  input wire logic [2:0][4:0] sampleChan,
  input wire logic [2:0] sampling,
  input wire logic [4:0] fire,
  // Sample words and trigger lines.
  output logic [2:0][11:0] coreSample,
  output logic [2:0][11:0] unusedPad,
  output logic [4:0] trigIn
);
  // Outside its sample phase a word shows a changed pattern.
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      unusedPad[k] = {sampleChan[k], 7'h2A};
      coreSample[k] = sampling[k] ? unusedPad[k] : ~unusedPad[k];
    end
  end
  always_ff @(posedge clk) begin
    trigIn <= fire;
  end
endmodule : mcas_front_end

/* verif/mcas_sequencer_properties.sv */
`timescale 1ns/1ps
// ==========
// Port checks of the sequencer.
module mcas_sequencer_properties #(parameter int NCHAN = 20) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Bus.
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Cores and interrupts.
  input wire logic [2:0][4:0] sampleChan,
  input wire logic [2:0] sampling,
  input wire logic [3:0] cmpIrq,
  input wire logic [3:0] fltIrq,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // An access waits one cycle, then is answered.
  sequence held_then_answered;
    waitrequest ##1 !waitrequest;
  endsequence
  // A sample phase lasts at least two periods of two clocks.
  sequence sample_hold;
    sampling[2] [*4];
  endsequence
  bus_answer_a: assert property ($rose(read || write) |-> held_then_answered)
    else $error("access not answered in its second cycle");
  bus_idle_a: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised without a request");
  ded_zero_a: assert property (
    sampling[0] |-> sampleChan[0] == 5'h00)
    else $error("first dedicated core on a foreign input");
  ded_one_a: assert property (
    sampling[1] |-> sampleChan[1] == 5'h01)
    else $error("second dedicated core on a foreign input");
  shared_chan_a: assert property (
    sampling[2] |-> sampleChan[2] >= 5'h02 && sampleChan[2] < NCHAN)
    else $error("shared core on an illegal input");
  chan_steady_a: assert property (
    sampling[2] ##1 sampling[2] |-> $stable(sampleChan[2]))
    else $error("input changed during sampling");
  sample_min_a: assert property ($rose(sampling[2]) |-> sample_hold)
    else $error("shared sample phase too short");
  ded_sample_a: assert property (
    $rose(sampling[0]) |-> sampling[0] [*4])
    else $error("dedicated sample phase too short");
  irq_any_a: assert property ((|cmpIrq || |fltIrq) |-> irq)
    else $error("unit interrupt without the summary line");
  irq_clear_a: assert property ($fell(irq) |-> $past(write))
    else $error("interrupt dropped without a write");
endmodule : mcas_sequencer_properties
bind mcas_sequencer mcas_sequencer_properties #(.NCHAN(NCHAN))
  i_mcas_sequencer_properties (.clk(clk), .reset_n(reset_n), .read(read),
  .write(write), .waitrequest(waitrequest), .sampleChan(sampleChan),
  .sampling(sampling), .cmpIrq(cmpIrq), .fltIrq(fltIrq), .irq(irq));

/* verif/test_multi_core_adc_sequencer.sv */
`timescale 1ns/1ps
// ==========
// Self-checking bench of the sequencer.
module test_multi_core_adc_sequencer;
  logic clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, both = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, irq;
  logic [4:0] trigIn, fire = 5'h00;
  logic [2:0][11:0] coreSample;
  logic [2:0][4:0] sampleChan;
  logic [2:0] sampling;
  logic [3:0] cmpIrq, fltIrq;
  logic [19:0] mask, fmt;
  logic [4:0] order[$];
  int failures = 0, compares = 0, cycles = 0, sw = 0, lastW = 0;
  int seed = 32'heb368c45;
  always #2.5 clk = ~clk;
  mcas_sequencer i_mcas_sequencer (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .trigIn(trigIn),
    .coreSample(coreSample), .sampleChan(sampleChan), .sampling(sampling),
    .cmpIrq(cmpIrq), .fltIrq(fltIrq), .irq(irq));
  mcas_front_end i_mcas_front_end (.clk(clk), .sampleChan(sampleChan),
    .sampling(sampling), .fire(fire), .coreSample(coreSample),
    .unusedPad(), .trigIn(trigIn));
  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      failures++;
      give_verdict();
    end
  end
  // Records shared-core order, overlap and sample width.
  always @(negedge clk) begin
    if (sampling[2] && sw == 0) order.push_back(sampleChan[2]);
    if (&sampling) both = 1'b1;
    if (sampling[2]) sw++;
    else if (sw != 0) begin
      lastW = sw;
      sw = 0;
    end
  end
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds one bus access until a rising edge sees waitrequest low.
  task automatic acc(input logic w, input logic [7:0] a, input int d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  // Polls until nothing is pending or busy.
  task automatic conv(input int c);
    if (c >= 0) acc(1'b1, mcas_pkg::OFS_SWTRIG, 1 << c);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 300; i++) begin
      acc(1'b0, mcas_pkg::OFS_PEND, 0);
      if (q[26:0] == 27'h0) break;
    end
  endtask : conv
  function automatic logic [31:0] expRes(input int c, input logic s,
                                         input int b = 12);
    logic [15:0] raw;
    raw = {4'h0, 5'(c), 7'h2A} >> (12 - b);
    return {16'h0, s ? raw - (16'h0001 << (b - 1)) : raw};
  endfunction : expRes
  function automatic int width(input int d, input int s);
    return (s + 2) * ((d < 2) ? 2 : 2 * d);
  endfunction : width
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, mcas_pkg::OFS_CORECFG + 8'h08, 0);
    chk(q, 32'h0030_0000);
    acc(1'b0, 8'hF0, 0);
    chk(q, 32'h0);
    fmt = 20'($random(seed));
    mask = 20'($random(seed)) | 20'h3;
    acc(1'b1, mcas_pkg::OFS_CTRL, 1);
    acc(1'b1, mcas_pkg::OFS_FORMAT, fmt);
    acc(1'b1, mcas_pkg::OFS_SWTRIG, mask);
    conv(-1);
    chk(both, 1);
    for (int c = 2; c < 20; c++) if (mask[c]) chk(order.pop_front(), c);
    for (int c = 0; c < 20; c++) begin
      if (mask[c]) begin
        acc(1'b0, mcas_pkg::OFS_RESULT + 8'(4 * c), 0);
        chk(q, expRes(c, fmt[c]));
      end
    end
    // Divider, sample time and resolution codes.
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, mcas_pkg::OFS_CORECFG + 8'h08,
        (i << 20) | ((3 - i) << 8) | (i * 2));
      conv(2);
      chk(lastW, width(i * 2, 3 - i));
      acc(1'b0, mcas_pkg::OFS_RESULT + 8'h08, 0);
      chk(q, expRes(2, fmt[2], 6 + 2 * i));
    end
    acc(1'b1, mcas_pkg::OFS_FORMAT, 0);
    acc(1'b1, mcas_pkg::OFS_MASK, 32'hFF);
    // Every comparator mode at the threshold.
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, mcas_pkg::OFS_STATUS, 32'h1FF);
      acc(1'b1, mcas_pkg::OFS_CMP, (32'h032A << 16) | 32'h8006 | (m << 8));
      chk(irq, 0);
      conv(6);
      chk(cmpIrq, (m == 0 || m == 2) ? 1 : 0);
    end
    acc(1'b1, mcas_pkg::OFS_FLT, 32'h8006);
    repeat (4) conv(6);
    chk(fltIrq, 1);
    acc(1'b0, mcas_pkg::OFS_FLT, 0);
    chk(q, 32'h0654_8006);
    acc(1'b1, mcas_pkg::OFS_FORMAT, 32'h80);
    acc(1'b1, mcas_pkg::OFS_TRIGSEL, 32'h5000_0000);
    fire <= 5'h10;
    repeat (4) @(posedge clk);
    fire <= 5'h00;
    conv(-1);
    acc(1'b0, mcas_pkg::OFS_RESULT + 8'h1C, 0);
    chk(q, expRes(7, 1'b1));
    acc(1'b1, mcas_pkg::OFS_CTRL, 0);
    acc(1'b1, mcas_pkg::OFS_SWTRIG, 32'h200);
    acc(1'b0, mcas_pkg::OFS_PEND, 0);
    chk(q, 32'h0);
    give_verdict();
  end
endmodule : test_multi_core_adc_sequencer
